//--- verilog/ea_pkg.sv
// Shared constants for the effective-address unit
package ea_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [7:0] DIRECT_HIGH = 8'h00;
  localparam logic [15:0] BIT_RMW_LIMIT = 16'h0080;
  localparam logic [15:0] PROG_BASE = 16'h0080;
  localparam logic [15:0] PC_STEP_1 = 16'h0001;
  localparam logic [15:0] PC_STEP_2 = 16'h0002;
  localparam logic [15:0] PC_STEP_3 = 16'h0003;
  localparam int OPC_BITNUM_LSB = 1;
  localparam int OPC_BITNUM_W = 3;
  localparam int OPC_BITCLR_POS = 0;
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX0, MODE_IX1, MODE_IX2,
    MODE_REL, MODE_BSC, MODE_BTB
  } addr_mode_t;
  typedef enum logic [1:0] {
    OP_REG, OP_RMW, OP_TST, OP_JUMP
  } op_class_t;
endpackage

//--- verilog/ea_mode_decode.sv
// Opcode row to addressing mode and operand class
`timescale 1ns/1ps
module ea_mode_decode
  import ea_pkg::*;
(
  input wire logic [7:0] opcode, // Instruction opcode
  output addr_mode_t mode, // Decoded addressing mode
  output op_class_t op_class // Operation class
);
  always_comb begin
    mode = MODE_INH;
    op_class = OP_REG;
    case (opcode[7:4])
      4'h0: mode = MODE_BTB;
      4'h1: mode = MODE_BSC;
      4'h2: mode = MODE_REL;
      4'h3: begin
        mode = MODE_DIR;
        op_class = (opcode[3:0] == 4'hd) ? OP_TST : OP_RMW;
      end
      4'h4, 4'h5, 4'h8, 4'h9: mode = MODE_INH;
      4'h6: begin
        mode = MODE_IX1;
        op_class = (opcode[3:0] == 4'hd) ? OP_TST : OP_RMW;
      end
      4'h7: begin
        mode = MODE_IX0;
        op_class = (opcode[3:0] == 4'hd) ? OP_TST : OP_RMW;
      end
      4'ha: mode = MODE_IMM;
      4'hb: mode = MODE_DIR;
      4'hc: mode = MODE_EXT;
      4'hd: mode = MODE_IX2;
      4'he: mode = MODE_IX1;
      4'hf: mode = MODE_IX0;
      default: mode = MODE_INH;
    endcase
    if (opcode[7] && opcode[3:1] == 3'h6) begin
      op_class = OP_JUMP;
    end
  end
endmodule // ea_mode_decode

//--- verilog/ea_bit_alter.sv
// Bit set, clear and test on one data byte
`timescale 1ns/1ps
module ea_bit_alter
  import ea_pkg::*;
(
  input wire logic [7:0] data_in, // Byte read from memory
  input wire logic [2:0] bit_num, // Bit number
  input wire logic set_bit, // High sets, low clears
  output logic [7:0] data_out, // Altered byte
  output logic bit_value // Tested bit
);
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_bit
      assign data_out[g] = (bit_num == 3'(g)) ? set_bit : data_in[g];
    end
  endgenerate
  assign bit_value = data_in[bit_num];
endmodule // ea_bit_alter

//--- verilog/cpu_effective_address_unit.sv
// Effective-address and program-counter advance unit
// Contract
// (RULE_01) Register/memory ops use A or X plus memory operand; jumps use PC.
// (RULE_02) Read-modify-write reads, alters, writes back; test op never writes.
// (RULE_03) Conditional branch adds signed offset when condition code test holds.
// (RULE_04) Inherent ops decode from opcode alone and fetch no operand bytes.
// (RULE_05) Immediate: address is PC+1, PC advances by two.
// (RULE_06) Direct: high byte zero, low byte from operand, PC plus two.
// (RULE_07) Extended: first operand high, second low, PC plus three.
// (RULE_08) Indexed no offset: address is 00:X, PC plus one.
// (RULE_09) Indexed 8-bit: X plus byte, carry to high, PC plus two.
// (RULE_10) Indexed 16-bit: X plus two-byte offset with carry, PC plus three.
// (RULE_11) Relative: PC+2 plus signed offset if taken, else PC+2.
// (RULE_12) Bit set/clear: two bytes, direct address, three-bit bit number.
// (RULE_13) Bit set/clear reaches the first 128 bytes.
// (RULE_14) Bit set/clear on program memory leaves it unchanged.
// (RULE_15) Bit test-and-branch reaches 256 locations, tested bit goes to carry.
// (RULE_16) Test-and-branch target is PC+3 plus signed third byte.
// (RULE_17) Address sums wrap modulo address space without exception.
`timescale 1ns/1ps
module cpu_effective_address_unit
  import ea_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic start, // Instruction bytes valid, begin
  input wire logic [7:0] opcode, // Opcode byte at PC
  input wire logic [7:0] operand1, // Byte at PC+1
  input wire logic [7:0] operand2, // Byte at PC+2
  input wire logic [15:0] pc, // Opcode address
  input wire logic [7:0] acc, // Accumulator
  input wire logic [7:0] index_x, // Index register
  input wire logic branch_cond, // Condition code test result
  input wire logic [7:0] mem_rdata, // Read data from memory
  output logic [7:0] addr_high, // Address bus high half
  output logic [7:0] addr_low, // Address bus low half
  output logic [15:0] effective_address, // Effective address
  output logic [15:0] pc_next, // Next program counter
  output logic [7:0] first_operand, // A or X, or PC low for jumps
  output logic mem_rd, // Read strobe
  output logic mem_wr, // Write strobe
  output logic [7:0] mem_wdata, // Write data
  output logic carry_load, // Load carry flag
  output logic carry_value, // Value for carry flag
  output logic jump_taken, // PC replaced by target
  output logic done // Instruction addressing complete
);
  typedef enum {ST_IDLE, ST_READ, ST_WRITE} st_t;
  st_t state_r;
  addr_mode_t mode, mode_r;
  op_class_t op_class, class_r;
  logic [7:0] opc_r, op1_r, op2_r;
  logic [15:0] pc_r;
  logic [15:0] ea_nxt, pcn_nxt;
  logic [8:0] ix_sum;
  logic [7:0] bit_out;
  logic bit_val;
  logic take; // Start accepted at this edge
  logic needs_read;
  logic bsc_write;
  logic rmw_write;
  logic btb_taken;
  logic [15:0] btb_target;
  logic x_first;

  ea_mode_decode u_dec (
    .opcode(opcode),
    .mode(mode),
    .op_class(op_class)
  );

  ea_bit_alter u_bit (
    .data_in(mem_rdata),
    .bit_num(opc_r[OPC_BITNUM_LSB +: OPC_BITNUM_W]), // RULE_12
    .set_bit(~opc_r[OPC_BITCLR_POS]),
    .data_out(bit_out),
    .bit_value(bit_val)
  );

  // Address and PC advance for the opcode being started
  always_comb begin
    ix_sum = {1'b0, index_x} + {1'b0, (mode == MODE_IX2) ? operand2 : operand1};
    ea_nxt = pc + PC_STEP_1;
    pcn_nxt = pc + PC_STEP_1;
    case (mode)
      MODE_INH: begin
        ea_nxt = pc; // RULE_04
        pcn_nxt = pc + PC_STEP_1; // RULE_04
      end
      MODE_IMM: begin
        ea_nxt = pc + PC_STEP_1; // RULE_05
        pcn_nxt = pc + PC_STEP_2; // RULE_05
      end
      MODE_DIR, MODE_BSC: begin
        ea_nxt = {DIRECT_HIGH, operand1}; // RULE_06 RULE_12
        pcn_nxt = pc + PC_STEP_2; // RULE_06 RULE_12
      end
      MODE_EXT: begin
        ea_nxt = {operand1, operand2}; // RULE_07
        pcn_nxt = pc + PC_STEP_3; // RULE_07
      end
      MODE_IX0: begin
        ea_nxt = {DIRECT_HIGH, index_x}; // RULE_08
        pcn_nxt = pc + PC_STEP_1; // RULE_08
      end
      MODE_IX1: begin
        ea_nxt = {7'h00, ix_sum}; // RULE_09
        pcn_nxt = pc + PC_STEP_2; // RULE_09
      end
      MODE_IX2: begin
        ea_nxt = {operand1 + {7'h00, ix_sum[8]}, ix_sum[7:0]}; // RULE_10 RULE_17
        pcn_nxt = pc + PC_STEP_3; // RULE_10
      end
      MODE_REL: begin
        // Signed offset from the next opcode, wraps at 64K
        ea_nxt = pc + PC_STEP_2 + {{8{operand1[7]}}, operand1}; // RULE_11 RULE_17
        pcn_nxt = branch_cond ? ea_nxt : pc + PC_STEP_2; // RULE_03 RULE_11
      end
      MODE_BTB: begin
        ea_nxt = {DIRECT_HIGH, operand1}; // RULE_15
        pcn_nxt = pc + PC_STEP_3 + {{8{operand2[7]}}, operand2}; // RULE_16 RULE_17
      end
      default: begin
        ea_nxt = pc;
        pcn_nxt = pc + PC_STEP_1;
      end
    endcase
  end

  // Latch the instruction for the memory phases
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opc_r <= 8'h00;
      op1_r <= 8'h00;
      op2_r <= 8'h00;
      pc_r <= 16'h0000;
      mode_r <= MODE_INH;
      class_r <= OP_REG;
    end else if (clk_en && start && state_r == ST_IDLE) begin
      opc_r <= opcode;
      op1_r <= operand1;
      op2_r <= operand2;
      pc_r <= pc;
      mode_r <= mode;
      class_r <= op_class;
    end
  end

  // Only an idle unit accepts; starts while busy are ignored
  assign take = clk_en && start && state_r == ST_IDLE;
  // Inherent, immediate, relative and jumps need no data read
  assign needs_read = mode == MODE_BSC || mode == MODE_BTB ||
    (op_class != OP_JUMP && mode != MODE_INH &&
    mode != MODE_REL && mode != MODE_IMM); // RULE_04
  // Bit ops above the RAM and I/O page never write, so program memory keeps its bytes
  assign bsc_write = mode_r == MODE_BSC &&
    {DIRECT_HIGH, op1_r} < BIT_RMW_LIMIT; // RULE_13 RULE_14
  // Test op only reads; other read-modify-write ops write back
  assign rmw_write = mode_r != MODE_BSC && mode_r != MODE_BTB &&
    class_r == OP_RMW; // RULE_02
  // Branch sense: low opcode bit set branches on a clear bit
  assign btb_taken = clk_en && state_r == ST_READ && mode_r == MODE_BTB &&
    (bit_val ^ opc_r[OPC_BITCLR_POS]); // RULE_16
  assign btb_target = pc_r + PC_STEP_3 + {{8{op2_r[7]}}, op2_r}; // RULE_16 RULE_17
  assign x_first = opcode[3:0] == 4'he || opcode[3:0] == 4'hf || opcode[3:0] == 4'h3;

  // Address bus halves stand until the next accepted instruction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      effective_address <= 16'h0000;
      addr_high <= 8'h00;
      addr_low <= 8'h00;
    end else if (take) begin
      effective_address <= ea_nxt; // RULE_17
      addr_high <= ea_nxt[15:8]; // RULE_06 RULE_09 RULE_10
      addr_low <= ea_nxt[7:0]; // RULE_08 RULE_09 RULE_10
    end
  end

  // Test-and-branch starts at PC+3 and moves to the target after the read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_next <= 16'h0000;
    end else if (take) begin
      if (op_class == OP_JUMP) begin
        pc_next <= ea_nxt; // RULE_01
      end else if (mode == MODE_BTB) begin
        pc_next <= pc + PC_STEP_3; // RULE_16
      end else begin
        pc_next <= pcn_nxt;
      end
    end else if (btb_taken) begin
      pc_next <= btb_target; // RULE_16
    end
  end

  // Jumps carry the PC; the rest pair A or X with the memory operand
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_operand <= 8'h00;
    end else if (take) begin
      if (op_class == OP_JUMP) begin
        first_operand <= pc[7:0]; // RULE_01
      end else if (x_first) begin
        first_operand <= index_x; // RULE_01
      end else begin
        first_operand <= acc; // RULE_01
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      jump_taken <= 1'b0;
    end else if (take) begin
      jump_taken <= op_class == OP_JUMP || (mode == MODE_REL && branch_cond); // RULE_03
    end else if (btb_taken) begin
      jump_taken <= 1'b1; // RULE_16
    end
  end

  // Memory phase sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          if (start && needs_read) begin
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (bsc_write || rmw_write) begin
            state_r <= ST_WRITE;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Strobes are one-cycle pulses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_rd <= 1'b0;
    end else if (clk_en) begin
      mem_rd <= take && needs_read;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (clk_en) begin
      mem_wr <= state_r == ST_READ && (bsc_write || rmw_write);
      if (state_r == ST_READ && bsc_write) begin
        mem_wdata <= bit_out; // RULE_12
      end else if (state_r == ST_READ && rmw_write) begin
        // ALU sits outside; the byte goes back as read
        mem_wdata <= mem_rdata; // RULE_02
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      carry_load <= 1'b0;
      carry_value <= 1'b0;
    end else if (clk_en) begin
      carry_load <= state_r == ST_READ && mode_r == MODE_BTB; // RULE_15
      if (state_r == ST_READ && mode_r == MODE_BTB) begin
        carry_value <= bit_val; // RULE_15
      end
    end
  end

  // Done closes every instruction, one to three cycles after the start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          done <= start && !needs_read; // RULE_04
        end
        ST_READ: begin
          done <= !(bsc_write || rmw_write);
        end
        ST_WRITE: begin
          done <= 1'b1;
        end
        default: begin
          done <= 1'b0;
        end
      endcase
    end
  end
endmodule // cpu_effective_address_unit

//--- verif/mem_model.sv
// Byte memory model answering the unit's read and write strobes
`timescale 1ns/1ps
module mem_model (
  input wire logic clk, // Core clock
  input wire logic [7:0] addr_low, // Low address byte
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata, // Write data
  output logic [7:0] mem_rdata // Read data
);
  logic [7:0] store [0:255];
  logic [7:0] last_r = 8'h00;
  // Idle bus shows the inverse of the last byte so a stale value never matches
  assign mem_rdata = mem_rd ? store[addr_low] : ~last_r;
  initial begin
    for (int i = 0; i < 256; i++) store[i] = 8'(i);
  end
  always @(posedge clk) begin
    if (mem_rd) last_r <= store[addr_low];
    if (mem_wr) store[addr_low] <= mem_wdata;
  end
endmodule // mem_model

//--- verif/cpu_effective_address_unit_asserts.sv
// Port assertions for the effective-address unit
`timescale 1ns/1ps
module ea_unit_checker (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic clk_en, // Enable
  input wire logic start, // Begin
  input wire logic [7:0] opcode, // Opcode
  input wire logic [7:0] operand1, // First byte
  input wire logic [7:0] operand2, // Second byte
  input wire logic [15:0] pc, // Opcode address
  input wire logic [7:0] index_x, // Index
  input wire logic branch_cond, // Condition
  input wire logic [7:0] addr_high, // Address high
  input wire logic [15:0] effective_address, // Address
  input wire logic [15:0] pc_next, // Next PC
  input wire logic mem_rd, // Read
  input wire logic mem_wr, // Write
  input wire logic carry_load, // Carry load
  input wire logic done // Done
);
  logic busy_r;
  logic take;
  logic [3:0] row;
  assign take = start && clk_en && (!busy_r || done);
  assign row = opcode[7:4];
  always_ff @(posedge clk) begin
    if (!reset_n) busy_r <= 1'b0;
    else if (take) busy_r <= 1'b1;
    else if (done) busy_r <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  imm_addr_a: assert property (take && row == 4'ha && opcode[3:1] != 3'b110 |=>
    done && effective_address == $past(pc) + 16'h0001 && pc_next == $past(pc) + 16'h0002)
    else $error("immediate address wrong");
  direct_addr_a: assert property (take && row == 4'hb && opcode[3:1] != 3'b110 |=>
    effective_address == {8'h00, $past(operand1)} && addr_high == 8'h00)
    else $error("direct address wrong");
  ext_addr_a: assert property (take && row == 4'hc |=>
    effective_address == {$past(operand1), $past(operand2)}) else $error("extended wrong");
  ix0_addr_a: assert property (take && row == 4'hf && opcode[3:1] != 3'b110 |=>
    effective_address == {8'h00, $past(index_x)} && pc_next == $past(pc) + 16'h0001)
    else $error("indexed zero offset wrong");
  ix1_carry_a: assert property (take && row == 4'he |=> effective_address ==
    16'($past(index_x)) + 16'($past(operand1))) else $error("indexed byte offset wrong");
  ix2_wrap_a: assert property (take && row == 4'hd |=> effective_address ==
    {$past(operand1), $past(operand2)} + 16'($past(index_x))) else $error("indexed wrong");
  rel_target_a: assert property (take && row == 4'h2 |=> pc_next ==
    $past(pc) + 16'h0002 + ($past(branch_cond) ? {{8{$past(operand1[7])}}, $past(operand1)}
    : 16'h0000)) else $error("relative target wrong");
  inh_quick_a: assert property (take && row inside {4'h4, 4'h5, 4'h8, 4'h9} |=>
    done && !mem_rd) else $error("inherent op touched memory");
  tst_nowrite_a: assert property (take && row == 4'h3 && opcode[3:0] == 4'hd |=>
    !mem_wr [*3]) else $error("test op wrote memory");
  prog_guard_a: assert property (take && row == 4'h1 && operand1[7] |=>
    !mem_wr [*3]) else $error("program memory written");
  test_carry_a: assert property (take && row == 4'h0 |=> mem_rd ##1
    (carry_load && done)) else $error("bit test carry missing");
  cover property (take && row == 4'h1 ##2 mem_wr);
  cover property (carry_load);
  cover property (take && row == 4'h2 && branch_cond);
endmodule // ea_unit_checker
bind cpu_effective_address_unit ea_unit_checker chk (.clk, .reset_n, .clk_en, .start,
  .opcode, .operand1, .operand2, .pc, .index_x, .branch_cond, .addr_high,
  .effective_address, .pc_next, .mem_rd, .mem_wr, .carry_load, .done);

//--- verif/cpu_effective_address_unit_tb.sv
// Self-checking bench for the effective-address unit
`timescale 1ns/1ps
module cpu_effective_address_unit_tb;
  import ea_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic clk_en = 1'b1;
  logic branch_cond = 1'b0;
  logic [7:0] opcode = 8'h9d, operand1 = 8'h00, operand2 = 8'h00;
  logic [7:0] acc = 8'h3c, index_x = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0] addr_high, addr_low, first_operand, mem_wdata, mem_rdata;
  logic [15:0] effective_address, pc_next;
  logic mem_rd, mem_wr, carry_load, carry_value, jump_taken, done, rd_seen, wr_seen;
  int miscompares = 0, num_checks = 0, cyc;
  cpu_effective_address_unit dut (.clk, .reset_n, .clk_en, .start, .opcode,
    .operand1, .operand2, .pc, .acc, .index_x, .branch_cond, .mem_rdata, .addr_high,
    .addr_low, .effective_address, .pc_next, .first_operand, .mem_rd, .mem_wr, .mem_wdata,
    .carry_load, .carry_value, .jump_taken, .done);
  mem_model mem_u (.clk, .addr_low, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [7:0] op, a, b, input logic [15:0] p, input logic bc);
    @(posedge clk);
    opcode <= op;
    operand1 <= a;
    operand2 <= b;
    pc <= p;
    branch_cond <= bc;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    cyc = 0;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    do begin
      @(negedge clk);
      cyc++;
      if (mem_rd === 1'b1) rd_seen = 1'b1;
      if (mem_wr === 1'b1) wr_seen = 1'b1;
    end while (done !== 1'b1 && cyc < 8);
  endtask
  task automatic t_plain;
    run(8'ha6, 8'h77, 8'h00, 16'h1234, 1'b0);
    check("imm ea", 16'h1235, effective_address);
    check("imm pc", 16'h1236, pc_next);
    run(8'hb6, 8'h5a, 8'h00, 16'h1234, 1'b0);
    check("dir ea", 16'h005a, {addr_high, addr_low});
    check("dir pc", 16'h1236, pc_next);
    check("acc operand", 16'h003c, {8'h00, first_operand});
    run(8'hce, 8'h12, 8'h34, 16'h1000, 1'b0);
    check("ext ea", 16'h1234, {addr_high, addr_low});
    check("ext pc", 16'h1003, pc_next);
    check("x operand", {8'h00, index_x}, {8'h00, first_operand});
    run(8'h4c, 8'h00, 8'h00, 16'h1000, 1'b0);
    check("inh fetch", 16'h0001, {15'h0000, !rd_seen && cyc == 1});
    $display("plain modes done");
  endtask
  task automatic t_indexed;
    index_x <= 8'hff;
    run(8'hf6, 8'h00, 8'h00, 16'h2000, 1'b0);
    check("ix0 ea", 16'h00ff, {addr_high, addr_low});
    check("ix0 pc", 16'h2001, pc_next);
    run(8'he6, 8'hff, 8'h00, 16'h2000, 1'b0);
    check("ix1 ea", 16'h01fe, {addr_high, addr_low});
    check("ix1 pc", 16'h2002, pc_next);
    index_x <= 8'h01;
    run(8'hd6, 8'hff, 8'hff, 16'h2000, 1'b0);
    check("ix2 ea", 16'h0000, effective_address);
    check("ix2 pc", 16'h2003, pc_next);
    $display("indexed modes done");
  endtask
  task automatic t_branch;
    run(8'h20, 8'h80, 8'h00, 16'h0010, 1'b1);
    check("rel taken", 16'hff92, pc_next);
    run(8'h20, 8'h80, 8'h00, 16'h0010, 1'b0);
    check("rel not taken", 16'h0012, pc_next);
    run(8'hbc, 8'h40, 8'h00, 16'h0010, 1'b0);
    check("jump operand", 16'h0010, {8'h00, first_operand});
    check("jump taken", 16'h0001, {15'h0000, jump_taken});
    $display("branches done");
  endtask
  task automatic t_bits;
    run(8'h16, 8'h10, 8'h00, 16'h0300, 1'b0);
    check("bset byte", 16'h0018, {8'h00, mem_u.store[8'h10]});
    check("bset pc", 16'h0302, pc_next);
    run(8'h1d, 8'h7f, 8'h00, 16'h0300, 1'b0);
    check("bclr edge", 16'h003f, {8'h00, mem_u.store[8'h7f]});
    run(8'h10, 8'h80, 8'h00, 16'h0300, 1'b0);
    check("prog byte", 16'h0080, {8'h00, mem_u.store[8'h80]});
    check("prog write", 16'h0000, {15'h0000, wr_seen});
    run(8'h08, 8'h10, 8'hfd, 16'h0040, 1'b0);
    check("btb taken", 16'h0040, pc_next);
    check("btb carry", 16'h0001, {15'h0000, carry_value});
    run(8'h09, 8'hf0, 8'hfd, 16'h0040, 1'b0);
    check("btb fall", 16'h0043, pc_next);
    run(8'h3d, 8'h20, 8'h00, 16'h0040, 1'b0);
    check("tst cycles", 16'h0002, 16'(cyc));
    check("tst byte", 16'h0020, {8'h00, mem_u.store[8'h20]});
    check("tst write", 16'h0000, {15'h0000, wr_seen});
    run(8'h3c, 8'h21, 8'h00, 16'h0040, 1'b0);
    check("rmw cycles", 16'h0003, 16'(cyc));
    check("rmw write", 16'h0001, {15'h0000, wr_seen});
    check("rmw byte", 16'h0021, {8'h00, mem_u.store[8'h21]});
    $display("bit and rmw done");
  endtask
  task automatic t_freeze;
    // Start held while disabled must leave pc_next and done as they were
    @(posedge clk);
    clk_en <= 1'b0;
    opcode <= 8'ha6;
    pc <= 16'h5000;
    start <= 1'b1;
    repeat (3) @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("frozen pc", 16'h0042, pc_next);
    check("frozen done", 16'h0000, {15'h0000, done});
    @(posedge clk);
    clk_en <= 1'b1;
    $display("clock enable done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_plain();
    t_indexed();
    t_branch();
    t_bits();
    t_freeze();
    give_verdict();
  end
  initial begin
    // About 17 operations of under 12 cycles each
    repeat (2000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule // cpu_effective_address_unit_tb
